//--- hdl/fpx_pkg.sv
// Constants for the floating-point status and exception control block
package fpx_pkg;
  // Status word geometry
  localparam int          FPX_W        = 16;
  localparam int          FPX_B_ERR    = 15;
  localparam int          FPX_B_GDIS   = 14;
  localparam int          FPX_B_RSV_HI = 13;
  localparam int          FPX_B_RSV_LO = 12;
  localparam int          FPX_B_UV     = 11;
  localparam int          FPX_B_UF     = 10;
  localparam int          FPX_B_OV     = 9;
  localparam int          FPX_B_IC     = 8;
  localparam logic [15:0] FPX_RESET    = 16'h0000;
  localparam logic [15:0] FPX_RSV_MASK = 16'h3000;

  // Exception codes
  localparam logic [3:0]  FPX_EC_NONE  = 4'h0;
  localparam logic [3:0]  FPX_EC_ILL   = 4'h2;
  localparam logic [3:0]  FPX_EC_DIV   = 4'h4;
  localparam logic [3:0]  FPX_EC_CONV  = 4'h6;
  localparam logic [3:0]  FPX_EC_OVF   = 4'h8;
  localparam logic [3:0]  FPX_EC_UNF   = 4'hA;
  localparam logic [3:0]  FPX_EC_UV    = 4'hC;

  // Shared vector, octal 244
  localparam logic [15:0] FPX_VECTOR   = 16'h00A4;

  // Exponent handling: biased field width, octal 400 wrap, top biased value
  localparam int          FPX_EXP_W    = 8;
  localparam int          FPX_FRAC_W   = 7;
  localparam logic [9:0]  FPX_EXP_WRAP = 10'h100;
  localparam logic [9:0]  FPX_EXP_MAX  = 10'h0FF;
  localparam logic [15:0] FPX_ZERO     = 16'h0000;

  // Result path state
  typedef enum logic [1:0] {
    FPX_RES_NORMAL,
    FPX_RES_TRAPPED,
    FPX_RES_FLUSHED
  } fpx_res_type;
endpackage

//--- hdl/fpx_mzero_detect.sv
// Minus-zero (undefined variable) pattern detector
`timescale 1ns/1ps
module fpx_mzero_detect
  import fpx_pkg::*;
(
  // High word of a floating value
  input  wire logic [15:0] word,
  // Pattern found
  output wire logic        is_mzero
);
  // Sign set and biased exponent zero, fraction ignored
  assign is_mzero = word[15] && (word[14:7] == 8'h00);
endmodule

//--- hdl/fpx_result_adjust.sv
// Result exponent adjustment for overflow and underflow
`timescale 1ns/1ps
module fpx_result_adjust
  import fpx_pkg::*;
(
  // Raw result from the datapath
  input  wire logic             sign,
  input  wire logic signed [9:0] exp_true,
  input  wire logic [6:0]       frac,
  input  wire logic             frac_zero,
  // Enables from the status word
  input  wire logic             uf_en,
  input  wire logic             ov_en,
  // Adjusted result
  output wire logic [15:0]      word,
  output wire logic             ovf,
  output wire logic             unf,
  output wire fpx_res_type      kind
);
  wire logic       over;      // Biased exponent above the field
  wire logic       under;     // Biased exponent at or below zero
  wire logic [7:0] exp_wrap;  // Exponent shifted by octal 400
  wire logic [9:0] exp_adj;   // Exponent after the wrap

  assign over     = !frac_zero && (exp_true > $signed(FPX_EXP_MAX));
  assign under    = !frac_zero && (exp_true <= $signed(10'h000));
  assign ovf      = over;
  assign unf      = under;
  // Overflow drops octal 400, underflow adds it; low byte is the same both ways
  assign exp_adj  = over ? (exp_true - FPX_EXP_WRAP) : (exp_true + FPX_EXP_WRAP);
  assign exp_wrap = exp_adj[7:0];

  // Untrapped overflow or underflow gives an exact zero
  assign kind = frac_zero                      ? FPX_RES_NORMAL :
                ((over && !ov_en) || (under && !uf_en)) ? FPX_RES_FLUSHED :
                (over || under)                 ? FPX_RES_TRAPPED : FPX_RES_NORMAL;

  // Zero results are stored exactly, never wrapped
  assign word = frac_zero                 ? FPX_ZERO :
                (kind == FPX_RES_FLUSHED) ? FPX_ZERO :
                (kind == FPX_RES_TRAPPED) ? {sign, exp_wrap, frac} :
                {sign, exp_true[7:0], frac};
endmodule

//--- hdl/fpx_status_ctrl.sv
// Floating-point status word upper half: error flag, disables, enables, traps
`timescale 1ns/1ps
module fpx_status_ctrl
  import fpx_pkg::*;
(
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              SRST,
  // Processor bus reset instruction
  input  wire logic              BUS_RESET,
  // Status load and store
  input  wire logic              STATUS_LOAD,
  input  wire logic [15:0]       LOAD_DATA,
  output logic      [15:0]       STATUS_WORD,
  // Operand fetch check
  input  wire logic              OPND_VALID,
  input  wire logic              OPND_FROM_MEM,
  input  wire logic              OPND_UV_CLASS,
  input  wire logic [15:0]       OPND_HI,
  output logic                   UV_ABORT,
  // Instruction completion report
  input  wire logic              EXC_VALID,
  input  wire logic              EXC_ILL_OP,
  input  wire logic              EXC_DIV_ZERO,
  input  wire logic              EXC_CONV_FAIL,
  // Raw result from the datapath
  input  wire logic              RES_VALID,
  input  wire logic              RES_SIGN,
  input  wire logic signed [9:0] RES_EXP,
  input  wire logic [6:0]        RES_FRAC,
  input  wire logic              RES_ZERO,
  // Adjusted result toward memory or accumulator
  output logic                   RESULT_VALID,
  output logic      [15:0]       RESULT_HI,
  output logic                   RESULT_ZERO_FILL,
  // Interrupt request toward the core
  output logic                   FP_IRQ_REQ,
  output logic      [15:0]       FP_IRQ_VECTOR,
  output logic      [3:0]        EXC_CODE
);

  // Stored status word and registered outputs
  logic [15:0] status;        // Status word, reserved bits held zero
  logic        uv_abort;      // Trap before execution
  logic        irq_req;       // One-cycle interrupt request
  logic [3:0]  exc_code;      // Code of the latest flagged exception
  logic        res_valid;     // Result strobe
  logic [15:0] res_hi;        // Adjusted result high word
  logic        res_zfill;     // Low words must be zeroed

  // Current control bits
  wire logic   gdis;          // Global interrupt disable
  wire logic   uv_en;         // Undefined-variable enable
  wire logic   uf_en;         // Underflow enable
  wire logic   ov_en;         // Overflow enable
  wire logic   ic_en;         // Integer conversion enable

  assign gdis  = status[FPX_B_GDIS];
  assign uv_en = status[FPX_B_UV];
  assign uf_en = status[FPX_B_UF];
  assign ov_en = status[FPX_B_OV];
  assign ic_en = status[FPX_B_IC];

  // Operand minus-zero check
  wire logic   opnd_mz;       // Fetched operand is minus-zero
  wire logic   uv_hit;        // Undefined-variable trap fires

  fpx_mzero_detect u_opnd_mz (
    .word     (OPND_HI),
    .is_mzero (opnd_mz)
  );

  // Accumulator operands never trap; enable clear lets minus-zero through
  assign uv_hit = OPND_VALID && OPND_FROM_MEM && OPND_UV_CLASS
                  && opnd_mz && uv_en;

  // Result adjustment
  wire logic [15:0] adj_word;  // Result after exponent handling
  wire logic        adj_ovf;   // Result overflowed
  wire logic        adj_unf;   // Result underflowed
  fpx_res_type      adj_kind;  // Normal, trapped or flushed
  wire logic        adj_mz;    // Adjusted word is minus-zero

  fpx_result_adjust u_adjust (
    .sign      (RES_SIGN),
    .exp_true  (RES_EXP),
    .frac      (RES_FRAC),
    .frac_zero (RES_ZERO),
    .uf_en     (uf_en),
    .ov_en     (ov_en),
    .word      (adj_word),
    .ovf       (adj_ovf),
    .unf       (adj_unf),
    .kind      (adj_kind)
  );

  fpx_mzero_detect u_res_mz (
    .word     (adj_word),
    .is_mzero (adj_mz)
  );

  // Exception sources; maskable ones count only when enabled
  wire logic ex_ill;          // Illegal opcode
  wire logic ex_div;          // Divide by zero
  wire logic ex_conv;         // Enabled conversion failure
  wire logic ex_ovf;          // Enabled overflow
  wire logic ex_unf;          // Enabled underflow
  wire logic err_set;         // Any flag-setting exception this cycle
  wire logic next_irq;        // Request to issue next cycle

  assign ex_ill  = EXC_VALID && EXC_ILL_OP;
  assign ex_div  = EXC_VALID && EXC_DIV_ZERO;
  assign ex_conv = EXC_VALID && EXC_CONV_FAIL && ic_en;
  assign ex_ovf  = RES_VALID && adj_ovf && ov_en;
  assign ex_unf  = RES_VALID && adj_unf && uf_en;
  // Flag set never looks at the global disable
  assign err_set = uv_hit || ex_ill || ex_div || ex_conv || ex_ovf || ex_unf;
  // Bus reset drops a request in flight, but the flag stays
  assign next_irq = err_set && !gdis && !BUS_RESET;

  // Code selection; the pre-execution trap comes first
  wire logic [3:0] next_code;  // Code for this cycle's exception
  assign next_code = uv_hit  ? FPX_EC_UV   :
                     ex_ill  ? FPX_EC_ILL  :
                     ex_div  ? FPX_EC_DIV  :
                     ex_conv ? FPX_EC_CONV :
                     ex_ovf  ? FPX_EC_OVF  :
                     ex_unf  ? FPX_EC_UNF  : exc_code;

  // Next status word
  wire logic [15:0] load_word;    // Loaded word, reserved bits dropped
  wire logic [15:0] base_word;    // Load or hold
  wire logic [15:0] next_status;  // Set wins over the load's clear

  assign load_word   = LOAD_DATA & ~FPX_RSV_MASK;
  assign base_word   = STATUS_LOAD ? load_word : status;
  // The hardware only ever ORs into the flag, never clears it
  assign next_status = base_word | {err_set, 15'h0000};

  // Result store: a minus-zero without an interrupt becomes clean zero
  wire logic [15:0] next_res_hi;  // Word to store
  wire logic        next_zfill;   // Zero the low words too
  wire logic        mz_unguard;   // Minus-zero with no request beside it

  assign mz_unguard  = adj_mz && !next_irq;
  assign next_res_hi = mz_unguard ? FPX_ZERO : adj_word;
  assign next_zfill  = mz_unguard || (adj_kind == FPX_RES_FLUSHED);

  // Status word register; SRST clears, bus reset does not touch it
  always_ff @(posedge CLK) begin
    if (SRST) begin
      status <= FPX_RESET;
    end else begin
      status <= next_status;
    end
  end

  // Interrupt request and exception code
  always_ff @(posedge CLK) begin
    if (SRST) begin
      irq_req  <= 1'b0;
      exc_code <= FPX_EC_NONE;
    end else begin
      irq_req  <= next_irq;
      exc_code <= next_code;
    end
  end

  // Pre-execution abort toward the sequencer
  always_ff @(posedge CLK) begin
    if (SRST) begin
      uv_abort <= 1'b0;
    end else begin
      uv_abort <= uv_hit;
    end
  end

  // Result register
  always_ff @(posedge CLK) begin
    if (SRST) begin
      res_valid <= 1'b0;
      res_hi    <= FPX_ZERO;
      res_zfill <= 1'b0;
    end else begin
      res_valid <= RES_VALID;
      res_hi    <= RES_VALID ? next_res_hi : res_hi;
      res_zfill <= RES_VALID && next_zfill;
    end
  end

  // Vector is fixed; held in a flop so the output is registered
  always_ff @(posedge CLK) begin
    if (SRST) begin
      FP_IRQ_VECTOR <= FPX_VECTOR;
    end else begin
      FP_IRQ_VECTOR <= FPX_VECTOR;
    end
  end

  // Output wiring from flops
  assign STATUS_WORD      = status;
  assign UV_ABORT         = uv_abort;
  assign FP_IRQ_REQ       = irq_req;
  assign EXC_CODE         = exc_code;
  assign RESULT_VALID     = res_valid;
  assign RESULT_HI        = res_hi;
  assign RESULT_ZERO_FILL = res_zfill;

  // Checks on the block's own behaviour
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  // Zero divisor sets the flag on the next edge
  property p_div_sets;
    ex_div |=> STATUS_WORD[FPX_B_ERR];
  endproperty
  a_div_sets: assert property (p_div_sets) else $error("div zero did not set flag");

  // Illegal opcode gives code 2 unless a trap came first
  property p_ill_code;
    ex_ill && !uv_hit |=> EXC_CODE == FPX_EC_ILL && STATUS_WORD[FPX_B_ERR];
  endproperty
  a_ill_code: assert property (p_ill_code) else $error("illegal opcode code wrong");

  // Disabled conversion failure alone leaves the flag clear
  property p_conv_masked;
    EXC_VALID && EXC_CONV_FAIL && !ic_en && !err_set && !STATUS_WORD[FPX_B_ERR]
      && !STATUS_LOAD |=> !STATUS_WORD[FPX_B_ERR];
  endproperty
  a_conv_masked: assert property (p_conv_masked) else $error("masked conversion flagged");

  // Flag sets even with the global disable set
  property p_set_gdis;
    err_set && gdis |=> STATUS_WORD[FPX_B_ERR] && !FP_IRQ_REQ;
  endproperty
  a_set_gdis: assert property (p_set_gdis) else $error("disable blocked flag");

  // Flag holds unless loaded
  property p_flag_hold;
    STATUS_WORD[FPX_B_ERR] && !STATUS_LOAD |=> STATUS_WORD[FPX_B_ERR];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag cleared without load");

  // Bus reset leaves the flag as it was
  property p_bus_reset;
    BUS_RESET && !STATUS_LOAD |=> STATUS_WORD[FPX_B_ERR] >= $past(STATUS_WORD[FPX_B_ERR]);
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("bus reset cleared flag");

  // No request while the global disable is set
  property p_gdis_quiet;
    STATUS_WORD[FPX_B_GDIS] |=> !FP_IRQ_REQ;
  endproperty
  a_gdis_quiet: assert property (p_gdis_quiet) else $error("request under disable");

  // Reserved bits always read zero
  property p_rsv_zero;
    STATUS_WORD[FPX_B_RSV_HI:FPX_B_RSV_LO] == 2'b00;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits not zero");

  // Memory minus-zero with enable gives abort, code 12 and request
  property p_uv_trap;
    uv_hit && !gdis && !BUS_RESET |=> UV_ABORT && FP_IRQ_REQ && EXC_CODE == FPX_EC_UV;
  endproperty
  a_uv_trap: assert property (p_uv_trap) else $error("undefined variable trap missing");

  // Accumulator operand never aborts
  property p_acc_quiet;
    !(OPND_VALID && OPND_FROM_MEM) |=> !UV_ABORT;
  endproperty
  a_acc_quiet: assert property (p_acc_quiet) else $error("accumulator operand trapped");

  // Enable clear never aborts
  property p_uv_off;
    !uv_en |=> !UV_ABORT;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("trap with enable clear");

  // Stored minus-zero always comes with a request
  property p_mz_guard;
    RESULT_VALID && RESULT_HI[15] && RESULT_HI[14:7] == 8'h00 |-> FP_IRQ_REQ;
  endproperty
  a_mz_guard: assert property (p_mz_guard) else $error("minus zero stored alone");

  // Untrapped overflow stores exact zero with the zero fill set
  property p_ovf_flush;
    RES_VALID && adj_ovf && !ov_en |=> RESULT_HI == FPX_ZERO && RESULT_ZERO_FILL;
  endproperty
  a_ovf_flush: assert property (p_ovf_flush) else $error("overflow not flushed");

  // Trapped overflow keeps the low exponent byte
  property p_ovf_wrap;
    RES_VALID && adj_ovf && ov_en |=> RESULT_HI[14:7] == $past(RES_EXP[7:0]);
  endproperty
  a_ovf_wrap: assert property (p_ovf_wrap) else $error("overflow exponent wrong");

  // Vector stays at its fixed value
  property p_vector;
    FP_IRQ_REQ |-> FP_IRQ_VECTOR == FPX_VECTOR;
  endproperty
  a_vector: assert property (p_vector) else $error("vector wrong");

  // Load writes control bits exactly when no exception interferes
  property p_load;
    STATUS_LOAD && !err_set |=> STATUS_WORD == ($past(LOAD_DATA) & ~FPX_RSV_MASK);
  endproperty
  a_load: assert property (p_load) else $error("status load mismatch");

  // Enabled underflow requests an interrupt with code 10
  property p_unf_irq;
    RES_VALID && adj_unf && uf_en && !gdis && !BUS_RESET && !uv_hit && !EXC_VALID
      |=> FP_IRQ_REQ && EXC_CODE == FPX_EC_UNF;
  endproperty
  a_unf_irq: assert property (p_unf_irq) else $error("underflow request missing");

  // Trapped underflow keeps the fraction and the low exponent byte
  property p_unf_wrap;
    RES_VALID && adj_unf && uf_en && !gdis && !BUS_RESET
      |=> RESULT_HI[6:0] == $past(RES_FRAC) && RESULT_HI[14:7] == $past(RES_EXP[7:0]);
  endproperty
  a_unf_wrap: assert property (p_unf_wrap) else $error("underflow result wrong");

  // Enabled overflow requests an interrupt with code 8
  property p_ovf_irq;
    RES_VALID && adj_ovf && ov_en && !gdis && !BUS_RESET && !uv_hit && !EXC_VALID
      |=> FP_IRQ_REQ && EXC_CODE == FPX_EC_OVF;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow request missing");

endmodule

//--- sim/fpx_seq_model.sv
// Sequencer and datapath stand-in that issues requests to the status block
`timescale 1ns/1ps
module fpx_seq_model (
  // Clock
  input  wire logic          CLK,
  // Requests toward the status block
  output logic               BUS_RESET,
  output logic               STATUS_LOAD,
  output logic        [15:0] LOAD_DATA,
  output logic               OPND_VALID,
  output logic               OPND_FROM_MEM,
  output logic               OPND_UV_CLASS,
  output logic        [15:0] OPND_HI,
  output logic               EXC_VALID,
  output logic               EXC_ILL_OP,
  output logic               EXC_DIV_ZERO,
  output logic               EXC_CONV_FAIL,
  output logic               RES_VALID,
  output logic               RES_SIGN,
  output logic signed [9:0]  RES_EXP,
  output logic        [6:0]  RES_FRAC,
  output logic               RES_ZERO
);
  // Quiet at time zero, exact zero flag included
  initial begin
    {BUS_RESET, STATUS_LOAD, OPND_VALID, EXC_VALID, RES_VALID, RES_ZERO} = '0;
    {OPND_FROM_MEM, OPND_UV_CLASS, EXC_ILL_OP, EXC_DIV_ZERO, EXC_CONV_FAIL, RES_SIGN} = '0;
    {LOAD_DATA, OPND_HI, RES_EXP, RES_FRAC} = '0;
  end
  // Strobes last one cycle; released qualifiers flip so stale values never pass
  task automatic finish();
    @(negedge CLK);
    {BUS_RESET, STATUS_LOAD, OPND_VALID, EXC_VALID, RES_VALID, RES_ZERO} = '0;
    {LOAD_DATA, OPND_HI, RES_EXP, RES_FRAC} = ~{LOAD_DATA, OPND_HI, RES_EXP, RES_FRAC};
    {OPND_FROM_MEM, OPND_UV_CLASS, EXC_ILL_OP, EXC_DIV_ZERO, EXC_CONV_FAIL, RES_SIGN} =
      ~{OPND_FROM_MEM, OPND_UV_CLASS, EXC_ILL_OP, EXC_DIV_ZERO, EXC_CONV_FAIL, RES_SIGN};
  endtask
  // Status load instruction
  task automatic load(input logic [15:0] d);
    @(negedge CLK);
    {STATUS_LOAD, LOAD_DATA} = {1'b1, d};
    finish();
  endtask
  // Processor bus reset instruction
  task automatic bus_rst();
    @(negedge CLK);
    BUS_RESET = 1'b1;
    finish();
  endtask
  // Operand fetch report
  task automatic opnd(input logic mem, input logic cls, input logic [15:0] h);
    @(negedge CLK);
    {OPND_VALID, OPND_FROM_MEM, OPND_UV_CLASS, OPND_HI} = {1'b1, mem, cls, h};
    finish();
  endtask
  // Completion report, one exception kind at a time
  task automatic exc(input logic ill, input logic dz, input logic cv);
    @(negedge CLK);
    {EXC_VALID, EXC_ILL_OP, EXC_DIV_ZERO, EXC_CONV_FAIL} = {1'b1, ill, dz, cv};
    finish();
  endtask
  // Raw datapath result
  task automatic res(input logic s, input logic signed [9:0] e, input logic [6:0] f,
                     input logic z);
    @(negedge CLK);
    {RES_VALID, RES_SIGN, RES_EXP, RES_FRAC, RES_ZERO} = {1'b1, s, e, f, z};
    finish();
  endtask
endmodule

//--- sim/testbench.sv
// Self-checking bench for the floating-point status and exception block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module testbench;
  import fpx_pkg::*;
  // Clock, reset and the request wires from the stand-in
  logic              clk, srst;
  wire               bus_reset, status_load, opnd_valid, opnd_from_mem, opnd_uv_class;
  wire               exc_valid, exc_ill_op, exc_div_zero, exc_conv_fail;
  wire               res_valid, res_sign, res_zero;
  wire        [15:0] load_data, opnd_hi;
  wire signed [9:0]  res_exp;
  wire        [6:0]  res_frac;
  // Block outputs
  logic       [15:0] status_word, result_hi, fp_irq_vector;
  logic              uv_abort, result_valid, result_zero_fill, fp_irq_req;
  logic       [3:0]  exc_code;
  // Expected state, pending notes and counters
  logic       [15:0] sw, hi;
  logic       [3:0]  code;
  logic       [39:0] q[$];
  logic       [39:0] exp_n;
  int                error_cnt, num_checks, cyc;
  // Output event as seen, laid out like a note
  wire        [39:0] seen = {result_valid, result_hi, result_zero_fill, uv_abort, fp_irq_req,
                             exc_code, status_word};

  fpx_seq_model i_seq (.CLK(clk), .BUS_RESET(bus_reset), .STATUS_LOAD(status_load),
    .LOAD_DATA(load_data), .OPND_VALID(opnd_valid), .OPND_FROM_MEM(opnd_from_mem),
    .OPND_UV_CLASS(opnd_uv_class), .OPND_HI(opnd_hi), .EXC_VALID(exc_valid),
    .EXC_ILL_OP(exc_ill_op), .EXC_DIV_ZERO(exc_div_zero), .EXC_CONV_FAIL(exc_conv_fail),
    .RES_VALID(res_valid), .RES_SIGN(res_sign), .RES_EXP(res_exp), .RES_FRAC(res_frac),
    .RES_ZERO(res_zero));
  fpx_status_ctrl i_dut (.CLK(clk), .SRST(srst), .BUS_RESET(bus_reset),
    .STATUS_LOAD(status_load), .LOAD_DATA(load_data), .STATUS_WORD(status_word),
    .OPND_VALID(opnd_valid), .OPND_FROM_MEM(opnd_from_mem), .OPND_UV_CLASS(opnd_uv_class),
    .OPND_HI(opnd_hi), .UV_ABORT(uv_abort), .EXC_VALID(exc_valid), .EXC_ILL_OP(exc_ill_op),
    .EXC_DIV_ZERO(exc_div_zero), .EXC_CONV_FAIL(exc_conv_fail), .RES_VALID(res_valid),
    .RES_SIGN(res_sign), .RES_EXP(res_exp), .RES_FRAC(res_frac), .RES_ZERO(res_zero),
    .RESULT_VALID(result_valid), .RESULT_HI(result_hi), .RESULT_ZERO_FILL(result_zero_fill),
    .FP_IRQ_REQ(fp_irq_req), .FP_IRQ_VECTOR(fp_irq_vector), .EXC_CODE(exc_code));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard, well above the roughly 80 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end
  // Watcher: every pulse on the outputs must match the oldest note
  always @(posedge clk) begin
    #1;
    if (!srst && (result_valid | uv_abort | fp_irq_req) !== 1'b0) begin
      exp_n = q.size() ? q.pop_front() : '0;
      `CHK("output event", exp_n, seen)
    end
  end

  // Note of one expected output event
  function automatic logic [39:0] note(logic rv, logic zf, logic ab, logic irq);
    return {rv, hi, zf, ab, irq, code, sw};
  endfunction
  // Status load, reserved bits read back zero
  task automatic do_load(input logic [15:0] d);
    sw = d & ~FPX_RSV_MASK;
    i_seq.load(d);
    `CHK("status word", sw, status_word)
  endtask
  // Completion report with one exception kind
  task automatic do_exc(input logic ill, input logic dz, input logic cv);
    if (ill | dz | (cv & sw[FPX_B_IC])) begin
      sw[FPX_B_ERR] = 1'b1;
      code = ill ? FPX_EC_ILL : (dz ? FPX_EC_DIV : FPX_EC_CONV);
      if (!sw[FPX_B_GDIS]) q.push_back(note(1'b0, 1'b0, 1'b0, 1'b1));
    end
    i_seq.exc(ill, dz, cv);
    `CHK("status after report", sw, status_word)
    `CHK("code after report", code, exc_code)
  endtask
  // Operand fetch, trap only for an enabled memory minus-zero
  task automatic do_opnd(input logic mem, input logic cls, input logic [15:0] h);
    if (mem & cls & sw[FPX_B_UV] & h[15] & (h[14:7] == 8'h00)) begin
      sw[FPX_B_ERR] = 1'b1;
      code = FPX_EC_UV;
      q.push_back(note(1'b0, 1'b0, 1'b1, !sw[FPX_B_GDIS]));
    end
    i_seq.opnd(mem, cls, h);
    `CHK("status after operand", sw, status_word)
  endtask
  // Result with overflow and underflow handling
  task automatic do_res(input logic s, input int e, input logic [6:0] f);
    logic ovf, unf, trap, irq, zf;
    ovf = e > 255;
    unf = e <= 0;
    trap = (ovf & sw[FPX_B_OV]) | (unf & sw[FPX_B_UF]);
    irq = trap & !sw[FPX_B_GDIS];
    hi = {s, e[7:0], f};
    zf = ((ovf | unf) & !trap) | (hi[15] & (hi[14:7] == 8'h00) & !irq);
    if (zf) hi = FPX_ZERO;
    if (trap) begin
      sw[FPX_B_ERR] = 1'b1;
      code = ovf ? FPX_EC_OVF : FPX_EC_UNF;
    end
    q.push_back(note(1'b1, zf, 1'b0, irq));
    i_seq.res(s, 10'(e), f, 1'b0);
  endtask
  // Exact zero result: stored clean, never trapped, whatever the exponent
  task automatic do_zero(input logic s, input int e);
    hi = FPX_ZERO;
    q.push_back(note(1'b1, 1'b0, 1'b0, 1'b0));
    i_seq.res(s, 10'(e), 7'h00, 1'b1);
  endtask

  // Closing report
  task automatic print_verdict();
    $display("Checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence
  initial begin
    srst = 1'b1;
    {sw, hi, code} = '0;
    void'($urandom(70373));
    repeat (6) @(negedge clk);
    srst = 1'b0;
    `CHK("status at reset", FPX_RESET, status_word)
    `CHK("vector", FPX_VECTOR, fp_irq_vector)
    `CHK("code at reset", FPX_EC_NONE, exc_code)
    repeat (4) do_load(16'($urandom()));
    do_load(16'hB000);
    do_load(16'h0000);
    // Global disable: flag and code still update, no request
    do_load(16'h4000);
    do_exc(1'b0, 1'b1, 1'b0);
    i_seq.bus_rst();
    `CHK("status after bus reset", sw, status_word)
    do_load(16'h0000);
    do_exc(1'b0, 1'b0, 1'b1);
    do_exc(1'b1, 1'b0, 1'b0);
    do_load(16'h0100);
    do_exc(1'b0, 1'b0, 1'b1);
    // Operand checks: memory, accumulator, class, pattern, enable
    do_load(16'h0800);
    do_opnd(1'b1, 1'b1, 16'h807F);
    do_opnd(1'b0, 1'b1, 16'h8000);
    do_opnd(1'b1, 1'b0, 16'h8000);
    do_opnd(1'b1, 1'b1, 16'h8080);
    do_load(16'h0000);
    do_opnd(1'b1, 1'b1, 16'h8000);
    // Results: plain, trapped, flushed, scrubbed minus-zero
    do_load(16'h0600);
    repeat (4) do_res(1'($urandom()), 1 + $urandom_range(254), 7'($urandom()));
    do_res(1'b0, 300, 7'h55);
    do_res(1'b1, -10, 7'h2A);
    do_res(1'b1, 256, 7'h01);
    do_zero(1'b1, -300);
    do_load(16'h0000);
    do_res(1'b0, 300, 7'h7F);
    do_res(1'b1, -5, 7'h33);
    do_load(16'h4400);
    do_res(1'b1, -256, 7'h11);
    repeat (4) @(negedge clk);
    `CHK("status at end", sw, status_word)
    `CHK("notes left", 0, q.size())
    print_verdict();
  end
endmodule
